// *** csl_buf2.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/10ps
module csl_buf2 (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire logic                  flush,
    // Fill side
    input  wire logic                  in_valid,
    output logic                       in_ready,
    input  wire logic [7:0]            in_data,
    // Drain side
    output logic                       out_valid,
    input  wire logic                  out_ready,
    output logic [7:0]                 out_data
);
    logic [7:0] mem_reg [2];
    logic       wr_ptr_reg;
    logic       rd_ptr_reg;
    logic [1:0] count_reg;
    logic       push;
    logic       pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else if (flush) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// *** csl_pkg.sv ***
// Package for the console serial line unit: register numbers, fields,
// line states, baud divisors and carrier types.
// Assumes a 25 MHz module clock and processor register access by number.
package csl_pkg;

    // Processor register numbers
    localparam logic [7:0] REG_RX_CSR  = 8'h20;
    localparam logic [7:0] REG_RX_DATA = 8'h21;
    localparam logic [7:0] REG_TX_CSR  = 8'h22;
    localparam logic [7:0] REG_TX_DATA = 8'h23;

    // Field positions
    localparam int BIT_RX_DONE  = 7;
    localparam int BIT_RX_INT   = 6;
    localparam int BIT_ERR      = 15;
    localparam int BIT_OVR      = 14;
    localparam int BIT_FRM      = 13;
    localparam int BIT_BRK      = 11;
    localparam int BIT_TX_RDY   = 7;
    localparam int BIT_TX_INT   = 6;
    localparam int BIT_LOOP     = 2;
    localparam int BIT_TX_BRK   = 0;
    localparam int BIT_CFG_KEEP = 7;
    localparam int BIT_BAUD_HI  = 14;
    localparam int BIT_BAUD_LO  = 12;

    // Character format
    localparam int DATA_BITS   = 8;
    localparam int BREAK_BITS  = 20;
    localparam int OVERSAMPLE  = 16;
    localparam int SAMPLE_MID  = 8;

    // Interrupt priority and vectors
    localparam logic [4:0] INT_LEVEL  = 5'h0E;
    localparam logic [8:0] RX_VECTOR  = 9'h0F8;
    localparam logic [8:0] TX_VECTOR  = 9'h0FC;

    // Clock and baud rates
    localparam int CLOCK_HZ = 25_000_000;

    // Oversample divisor per baud code: 300..38400 baud
    localparam int BAUD_TABLE [8] = '{300, 600, 1200, 2400,
                                      4800, 9600, 19200, 38400};

    function automatic logic [15:0] baud_divisor(input logic [2:0] code);
        int div;
        div = CLOCK_HZ / (BAUD_TABLE[code] * OVERSAMPLE);
        baud_divisor = 16'(div - 1);
    endfunction

    // Line states
    localparam logic LINE_MARK  = 1'b1;
    localparam logic LINE_SPACE = 1'b0;

    // Received character with status
    typedef struct packed {
        logic       brk;
        logic       frm;
        logic [7:0] data;
    } csl_rx_char_t;

    // Register access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  num;
        logic [31:0] wdata;
    } csl_req_t;

endpackage

// *** csl_term_model.sv ***
// Serial terminal model at the far end of the console line.
// Assumes 8N1 frames of a fixed bit length in clock cycles.
`timescale 1ns/10ps
module csl_term_model #(
    parameter int BIT_CLKS = 640
) (
    // Clock
    input  wire logic clock,
    // Line from and to the unit
    input  wire logic line_in,
    output logic      line_out
);
    logic [7:0] rx_q [$];
    logic [7:0] sh;
    initial line_out = csl_pkg::LINE_MARK;
    // Sends one frame; a space stop bit makes a framing fault
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, csl_pkg::LINE_SPACE};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (BIT_CLKS) @(posedge clock);
        end
        line_out <= csl_pkg::LINE_MARK;
    endtask
    task automatic hold_space(input int bits);
        line_out <= csl_pkg::LINE_SPACE;
        repeat (bits * BIT_CLKS) @(posedge clock);
        line_out <= csl_pkg::LINE_MARK;
    endtask
    // Samples mid-bit, LSB first; keeps frames with a mark stop bit
    initial begin
        forever begin
            @(negedge line_in);
            repeat (BIT_CLKS / 2) @(posedge clock);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CLKS) @(posedge clock);
                sh = {line_in, sh[7:1]};
            end
            repeat (BIT_CLKS) @(posedge clock);
            if (line_in) rx_q.push_back(sh);
        end
    end
endmodule

// *** csl_unit.sv ***
// Console serial line unit: receiver, transmitter and four registers.
// Assumes synchronous inputs on a 25 MHz clock and register access by
// processor register number with one-cycle read and write strobes.
`timescale 1ns/10ps
module csl_unit (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // Power good and configuration
    input  wire logic                  dc_power_good,
    input  wire logic [31:0]           config_reg_value,
    // Processor register access
    input  wire csl_pkg::csl_req_t     req,
    output logic [31:0]                rdata_reg,
    // Serial line
    input  wire logic                  serial_in,
    output logic                       serial_out_reg,
    // Interrupt requests
    output logic                       rx_int_req_reg,
    output logic                       tx_int_req_reg,
    output logic [4:0]                 int_level_reg,
    output logic [8:0]                 int_vector_reg
);
    // Power good negation edge
    logic       pg_dly_reg;
    logic       pg_drop;
    // Register bits
    logic       rx_int_enable_reg;
    logic       tx_int_enable_reg;
    logic       loopback_self_test_reg;
    logic       transmit_break_reg;
    logic       rx_done_reg;
    logic       overrun_flag_reg;
    logic       framing_error_flag_reg;
    logic       received_break_flag_reg;
    logic [7:0] rx_data_reg;
    // Baud tick
    logic [15:0] tick_cnt_reg;
    logic        tick;
    logic [2:0]  baud_code;
    // Receiver
    logic        rx_line;
    logic [3:0]  rx_os_reg;
    logic [3:0]  rx_bit_reg;
    logic [7:0]  rx_shift_reg;
    logic [4:0]  space_cnt_reg;
    logic        brk_armed_reg;
    logic        rx_got;
    csl_pkg::csl_rx_char_t rx_char;
    // Transmitter
    logic [3:0]  tx_os_reg;
    logic [3:0]  tx_bit_reg;
    logic [8:0]  tx_shift_reg;
    logic        tx_line_reg;
    logic        tx_ready;
    logic        tx_valid;
    logic [7:0]  tx_char;
    logic        tx_take;
    logic        tx_load;
    logic        rd_rx_buf;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} csl_rx_state_t;
    typedef enum {TX_IDLE, TX_SEND} csl_tx_state_t;
    csl_rx_state_t rx_state_reg;
    csl_tx_state_t tx_state_reg;

    function automatic logic hit(input csl_pkg::csl_req_t r,
                                 input logic [7:0] num);
        hit = (r.num == num);
    endfunction

    assign pg_drop = pg_dly_reg && !dc_power_good;
    assign rd_rx_buf = req.rd && hit(req, csl_pkg::REG_RX_DATA);
    assign tx_load = req.wr && hit(req, csl_pkg::REG_TX_DATA);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pg_dly_reg <= 1'b1;
        end else begin
            pg_dly_reg <= dc_power_good;
        end
    end

    // Control bits
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_int_enable_reg      <= 1'b0;
            tx_int_enable_reg      <= 1'b0;
            loopback_self_test_reg <= 1'b0;
            transmit_break_reg     <= 1'b0;
        end else if (pg_drop) begin
            if (!config_reg_value[csl_pkg::BIT_CFG_KEEP]) begin
                rx_int_enable_reg <= 1'b0;
            end
            tx_int_enable_reg      <= 1'b0;
            loopback_self_test_reg <= 1'b0;
        end else if (req.wr && hit(req, csl_pkg::REG_RX_CSR)) begin
            rx_int_enable_reg <= req.wdata[csl_pkg::BIT_RX_INT];
        end else if (req.wr && hit(req, csl_pkg::REG_TX_CSR)) begin
            tx_int_enable_reg      <= req.wdata[csl_pkg::BIT_TX_INT];
            loopback_self_test_reg <= req.wdata[csl_pkg::BIT_LOOP];
            transmit_break_reg     <= req.wdata[csl_pkg::BIT_TX_BRK];
        end
    end

    // Shared baud tick at sixteen times the bit rate
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_reg <= 16'h0000;
        end else if (tick) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end
    assign baud_code = config_reg_value[csl_pkg::BIT_BAUD_HI:
                                        csl_pkg::BIT_BAUD_LO];
    assign tick      = (tick_cnt_reg >= csl_pkg::baud_divisor(baud_code));

    // Receiver input, looped back in self test
    assign rx_line = loopback_self_test_reg ? tx_line_reg : serial_in;

    // Receiver sequence
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_state_reg <= RX_IDLE;
            rx_os_reg    <= 4'h0;
            rx_bit_reg   <= 4'h0;
            rx_shift_reg <= 8'h00;
        end else if (tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            unique case (rx_state_reg)
                RX_IDLE: begin
                    rx_os_reg <= 4'h0;
                    if (rx_line == csl_pkg::LINE_SPACE) begin
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_os_reg == 4'(csl_pkg::SAMPLE_MID - 1)) begin
                        rx_os_reg <= 4'h0;
                        rx_bit_reg <= 4'h0;
                        rx_state_reg <= (rx_line == csl_pkg::LINE_SPACE) ?
                                        RX_DATA : RX_IDLE;
                    end
                end
                RX_DATA: begin
                    if (rx_os_reg == 4'(csl_pkg::OVERSAMPLE - 1)) begin
                        rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                        rx_bit_reg   <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg == 4'(csl_pkg::DATA_BITS - 1)) begin
                            rx_state_reg <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_os_reg == 4'(csl_pkg::OVERSAMPLE - 1)) begin
                        rx_state_reg <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Stop bit sample ends the character
    assign rx_got = tick && (rx_state_reg == RX_STOP) &&
                    (rx_os_reg == 4'(csl_pkg::OVERSAMPLE - 1));

    // Space bit counter for break detection
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            space_cnt_reg <= 5'h00;
            brk_armed_reg <= 1'b1;
        end else if (tick && (rx_os_reg == 4'(csl_pkg::SAMPLE_MID - 1))) begin
            if (rx_line == csl_pkg::LINE_MARK) begin
                space_cnt_reg <= 5'h00;
                brk_armed_reg <= 1'b1;
            end else if (space_cnt_reg != 5'(csl_pkg::BREAK_BITS)) begin
                space_cnt_reg <= space_cnt_reg + 5'h01;
            end
        end else if (rx_got && rx_char.brk) begin
            brk_armed_reg <= 1'b0;
        end
    end

    assign rx_char.data = rx_shift_reg;
    assign rx_char.frm  = (rx_line != csl_pkg::LINE_MARK);
    assign rx_char.brk  = brk_armed_reg &&
                          (space_cnt_reg == 5'(csl_pkg::BREAK_BITS));

    // Receive data and flags; a new character wins over a read
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_done_reg             <= 1'b0;
            overrun_flag_reg        <= 1'b0;
            framing_error_flag_reg  <= 1'b0;
            received_break_flag_reg <= 1'b0;
            rx_data_reg             <= 8'h00;
        end else if (pg_drop) begin
            rx_done_reg             <= 1'b0;
            overrun_flag_reg        <= 1'b0;
            framing_error_flag_reg  <= 1'b0;
            received_break_flag_reg <= 1'b0;
        end else if (rx_got) begin
            rx_data_reg             <= rx_char.data;
            rx_done_reg             <= 1'b1;
            overrun_flag_reg        <= rx_done_reg && !rd_rx_buf;
            framing_error_flag_reg  <= rx_char.frm || rx_char.brk;
            received_break_flag_reg <= rx_char.brk;
        end else if (rd_rx_buf) begin
            rx_done_reg             <= 1'b0;
            overrun_flag_reg        <= 1'b0;
            framing_error_flag_reg  <= 1'b0;
            received_break_flag_reg <= 1'b0;
        end
    end

    // Transmit buffer; a load while full is dropped
    csl_buf2 u_tx_buf (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .flush     (pg_drop),
        .in_valid  (tx_load),
        .in_ready  (tx_ready),
        .in_data   (req.wdata[7:0]),
        .out_valid (tx_valid),
        .out_ready (tx_take),
        .out_data  (tx_char)
    );

    assign tx_take = tick && (tx_state_reg == TX_IDLE);

    // Transmitter sequence
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state_reg <= TX_IDLE;
            tx_os_reg    <= 4'h0;
            tx_bit_reg   <= 4'h0;
            tx_shift_reg <= 9'h1FF;
            tx_line_reg  <= csl_pkg::LINE_MARK;
        end else if (tick) begin
            unique case (tx_state_reg)
                TX_IDLE: begin
                    tx_line_reg <= csl_pkg::LINE_MARK;
                    if (tx_valid) begin
                        tx_shift_reg <= {csl_pkg::LINE_MARK, tx_char};
                        tx_line_reg  <= csl_pkg::LINE_SPACE;
                        tx_os_reg    <= 4'h0;
                        tx_bit_reg   <= 4'h0;
                        tx_state_reg <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    tx_os_reg <= tx_os_reg + 4'h1;
                    if (tx_os_reg == 4'(csl_pkg::OVERSAMPLE - 1)) begin
                        tx_line_reg  <= tx_shift_reg[0];
                        tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
                        tx_bit_reg   <= tx_bit_reg + 4'h1;
                        if (tx_bit_reg == 4'(csl_pkg::DATA_BITS + 1)) begin
                            tx_line_reg  <= csl_pkg::LINE_MARK;
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Line output: mark in self test, space during break when idle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            serial_out_reg <= csl_pkg::LINE_MARK;
        end else if (loopback_self_test_reg) begin
            serial_out_reg <= csl_pkg::LINE_MARK;
        end else if (transmit_break_reg && tx_state_reg == TX_IDLE) begin
            serial_out_reg <= csl_pkg::LINE_SPACE;
        end else begin
            serial_out_reg <= tx_line_reg;
        end
    end

    // Register read data
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (req.rd) begin
            rdata_reg <= 32'h0000_0000;
            unique case (req.num)
                csl_pkg::REG_RX_CSR: begin
                    rdata_reg[csl_pkg::BIT_RX_DONE] <= rx_done_reg;
                    rdata_reg[csl_pkg::BIT_RX_INT]  <= rx_int_enable_reg;
                end
                csl_pkg::REG_RX_DATA: begin
                    rdata_reg[7:0]              <= rx_data_reg;
                    rdata_reg[csl_pkg::BIT_ERR] <= overrun_flag_reg ||
                                                   framing_error_flag_reg;
                    rdata_reg[csl_pkg::BIT_OVR] <= overrun_flag_reg;
                    rdata_reg[csl_pkg::BIT_FRM] <= framing_error_flag_reg;
                    rdata_reg[csl_pkg::BIT_BRK] <= received_break_flag_reg;
                end
                csl_pkg::REG_TX_CSR: begin
                    rdata_reg[csl_pkg::BIT_TX_RDY] <= tx_ready;
                    rdata_reg[csl_pkg::BIT_TX_INT] <= tx_int_enable_reg;
                    rdata_reg[csl_pkg::BIT_LOOP]   <= loopback_self_test_reg;
                    rdata_reg[csl_pkg::BIT_TX_BRK] <= transmit_break_reg;
                end
                default: begin
                    rdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Interrupt requests, receive ahead of transmit for the vector
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_int_req_reg <= 1'b0;
            tx_int_req_reg <= 1'b0;
            int_level_reg  <= 5'h00;
            int_vector_reg <= 9'h000;
        end else begin
            rx_int_req_reg <= rx_int_enable_reg && rx_done_reg;
            tx_int_req_reg <= tx_int_enable_reg && tx_ready;
            int_level_reg  <= csl_pkg::INT_LEVEL;
            int_vector_reg <= (rx_int_enable_reg && rx_done_reg) ?
                              csl_pkg::RX_VECTOR : csl_pkg::TX_VECTOR;
        end
    end
endmodule

// *** csl_unit_checker.sv ***
// Checker for the console serial line unit, bound to its top ports.
// Assumes one clock and the register timing of the unit's notes.
`timescale 1ns/10ps
module csl_unit_checker (
    // Clock and reset
    input wire logic              clock,
    input wire logic              sys_rst,
    // Watched ports
    input wire logic              dc_power_good,
    input wire csl_pkg::csl_req_t req,
    input wire logic [31:0]       rdata_reg,
    input wire logic              serial_out_reg,
    input wire logic              rx_int_req_reg,
    input wire logic              tx_int_req_reg,
    input wire logic [4:0]        int_level_reg,
    input wire logic [8:0]        int_vector_reg
);
    logic pg_reg;
    logic tx_en_reg;
    logic loop_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Tracks transmit enable and loopback from writes and power loss
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pg_reg <= 1'b1;
            tx_en_reg <= 1'b0;
            loop_reg <= 1'b0;
        end else begin
            pg_reg <= dc_power_good;
            if (pg_reg && !dc_power_good) begin
                tx_en_reg <= 1'b0;
                loop_reg <= 1'b0;
            end else if (req.wr && req.num == csl_pkg::REG_TX_CSR) begin
                tx_en_reg <= req.wdata[csl_pkg::BIT_TX_INT];
                loop_reg <= req.wdata[csl_pkg::BIT_LOOP];
            end
        end
    end
    level_fixed_a: assert property (
        !$past(sys_rst) |-> int_level_reg == 5'h0E)
        else $error("interrupt level wrong");
    rx_vector_a: assert property (
        rx_int_req_reg |-> int_vector_reg == 9'h0F8)
        else $error("receive vector wrong");
    tx_vector_a: assert property (
        tx_int_req_reg && !rx_int_req_reg |-> int_vector_reg == 9'h0FC)
        else $error("transmit vector wrong");
    tx_enable_a: assert property (
        tx_int_req_reg |->
        tx_en_reg || $past(tx_en_reg) || $past(tx_en_reg, 2))
        else $error("transmit request without enable");
    rx_status_a: assert property (
        req.rd && req.num == csl_pkg::REG_RX_CSR |=>
        rdata_reg[31:8] == 24'h00_0000 && rdata_reg[5:0] == 6'h00)
        else $error("receive status unused bits set");
    rx_error_sum_a: assert property (
        req.rd && req.num == csl_pkg::REG_RX_DATA |=>
        rdata_reg[15] == (rdata_reg[14] | rdata_reg[13])
        && rdata_reg[31:16] == 16'h0000 && rdata_reg[12] == 1'b0)
        else $error("receive data summary bit wrong");
    unmapped_read_a: assert property (
        req.rd && (req.num < 8'h20 || req.num > 8'h23) |=>
        rdata_reg == 32'h0000_0000)
        else $error("unmapped register read not zero");
    read_clear_a: assert property (
        req.rd && req.num == csl_pkg::REG_RX_DATA |=> ##1 !rx_int_req_reg)
        else $error("receive request stays after read");
    loop_mark_a: assert property (
        loop_reg && $past(loop_reg) |-> serial_out_reg)
        else $error("line not at mark in loopback");
endmodule
bind csl_unit csl_unit_checker csl_unit_checker_i (.clock, .sys_rst,
    .dc_power_good, .req, .rdata_reg, .serial_out_reg, .rx_int_req_reg,
    .tx_int_req_reg, .int_level_reg, .int_vector_reg);

// *** csl_unit_tb.sv ***
// Self-checking bench for the console serial line unit.
// Assumes a terminal model on the line and baud code 7.
`timescale 1ns/10ps
module csl_unit_tb;
    logic clock, sys_rst, dc_power_good, serial_in, serial_out_reg;
    logic rx_int_req_reg, tx_int_req_reg;
    logic [31:0] config_reg_value, rdata_reg, v;
    logic [4:0] int_level_reg;
    logic [8:0] int_vector_reg;
    logic [7:0] d [4];
    csl_pkg::csl_req_t req;
    int fail_count, checked, seed, n;
    csl_unit csl_unit_i (.clock, .sys_rst, .dc_power_good, .config_reg_value,
        .req, .rdata_reg, .serial_in, .serial_out_reg, .rx_int_req_reg,
        .tx_int_req_reg, .int_level_reg, .int_vector_reg);
    csl_term_model csl_term_model_i (.clock(clock), .line_in(serial_out_reg),
        .line_out(serial_in));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    function automatic logic [31:0] rxw(logic [7:0] c, logic o, f, b);
        return {16'h0000, o | f, o, f, 1'b0, b, 3'h0, c};
    endfunction
    task automatic chk(string what, logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", what, e, g);
            fail_count++;
        end
    endtask
    task automatic wr(logic [7:0] num, logic [31:0] wd);
        @(posedge clock);
        req <= '{rd: 1'b0, wr: 1'b1, num: num, wdata: wd};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] num, output logic [31:0] q);
        @(posedge clock);
        req <= '{rd: 1'b1, wr: 1'b0, num: num, wdata: 32'h0000_0000};
        @(posedge clock);
        req.rd <= 1'b0;
        @(posedge clock);
        #1 q = rdata_reg;
    endtask
    task automatic rc(logic [7:0] num, logic [31:0] e, string what);
        rd(num, v);
        chk(what, e, v);
    endtask
    task automatic wait_rx();
        for (int i = 0; i < 8000 && rx_int_req_reg !== 1'b1; i++)
            @(posedge clock);
        chk("rx request", 32'd1, 32'(rx_int_req_reg));
    endtask
    task automatic wait_q(int k);
        for (int i = 0; i < 26000 && csl_term_model_i.rx_q.size() < k; i++)
            @(posedge clock);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        conclude();
    end
    initial begin
        seed = 42491;
        fail_count = 0;
        checked = 0;
        sys_rst = 1'b1;
        dc_power_good = 1'b1;
        config_reg_value = 32'h0000_7000;
        req = '0;
        for (int i = 0; i < 4; i++) d[i] = 8'($random(seed));
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        rc(csl_pkg::REG_RX_CSR, 32'h0000_0000, "rx control");
        rc(csl_pkg::REG_TX_CSR, 32'h0000_0080, "tx control");
        rc(8'h24, 32'h0000_0000, "unmapped");
        wr(csl_pkg::REG_RX_DATA, 32'hFFFF_FFFF);
        rc(csl_pkg::REG_RX_DATA, 32'h0000_0000, "rx data");
        wr(csl_pkg::REG_RX_CSR, 32'hFFFF_FFFF);
        rc(csl_pkg::REG_RX_CSR, 32'h0000_0040, "rx control");
        // Two unread characters, then a bad stop bit
        csl_term_model_i.send(d[0], 1'b1);
        wait_rx();
        csl_term_model_i.send(d[1], 1'b1);
        rc(csl_pkg::REG_RX_DATA, rxw(d[1], 1, 0, 0), "overrun");
        rc(csl_pkg::REG_RX_CSR, 32'h0000_0040, "rx done");
        csl_term_model_i.send(d[2], 1'b0);
        wait_rx();
        rc(csl_pkg::REG_RX_DATA, rxw(d[2], 0, 1, 0), "framing");
        // Long space: one break, with framing error
        n = 0;
        fork
            csl_term_model_i.hold_space(30);
        join_none
        repeat (26000) begin
            @(posedge clock);
            if (rx_int_req_reg === 1'b1) begin
                rd(csl_pkg::REG_RX_DATA, v);
                if (v[11]) n++;
                if (v[11]) chk("break framing", 32'd1, 32'(v[13]));
            end
        end
        chk("break count", 32'd1, 32'(n));
        // Transmit until refused, then drain
        wr(csl_pkg::REG_TX_CSR, 32'h0000_0040);
        rd(csl_pkg::REG_TX_CSR, v);
        chk("tx request", 32'd1, 32'(tx_int_req_reg));
        n = 0;
        while (v[7] && n < 4) begin
            wr(csl_pkg::REG_TX_DATA, {24'h00_0000, d[n]});
            n++;
            rd(csl_pkg::REG_TX_CSR, v);
        end
        chk("tx ready full", 32'd0, 32'(v[7]));
        wait_q(n);
        for (int i = 0; i < n; i++)
            chk("tx char", d[i], csl_term_model_i.rx_q[i]);
        chk("tx request", 32'd1, 32'(tx_int_req_reg));
        csl_term_model_i.rx_q.delete();
        // Loopback at the next lower rate returns the character inside
        config_reg_value[14:12] <= 3'h6;
        wr(csl_pkg::REG_TX_CSR, 32'h0000_0004);
        wr(csl_pkg::REG_TX_DATA, {24'h00_0000, d[3]});
        repeat (7000) @(posedge clock);
        chk("slow rate", 32'd0, 32'(rx_int_req_reg));
        wait_rx();
        rc(csl_pkg::REG_RX_DATA, rxw(d[3], 0, 0, 0), "loop data");
        config_reg_value[14:12] <= 3'h7;
        chk("line quiet", 32'd0, csl_term_model_i.rx_q.size());
        // Transmit break after the buffered character
        wr(csl_pkg::REG_TX_CSR, 32'h0000_0001);
        wr(csl_pkg::REG_TX_DATA, {24'h00_0000, d[0]});
        wait_q(1);
        repeat (640) @(posedge clock);
        chk("break char", d[0], csl_term_model_i.rx_q[0]);
        chk("break line", 32'd0, 32'(serial_out_reg));
        // Power loss with and without the keep bit
        for (int k = 1; k >= 0; k--) begin
            wr(csl_pkg::REG_TX_CSR, 32'h0000_0044);
            config_reg_value[7] <= k[0];
            dc_power_good <= 1'b0;
            @(posedge clock);
            dc_power_good <= 1'b1;
            rc(csl_pkg::REG_RX_CSR, {25'h0, k[0], 6'h0}, "rx keep");
            rc(csl_pkg::REG_TX_CSR, 32'h0000_0080, "tx cleared");
        end
        conclude();
    end
endmodule
